/* File: rtl/dmabms_pkg.sv */
// Purpose: shared constants and types for the dma bus-mode and indirect sequencer
// Assumes: four channels, dual address mode, 32-bit internal data path
// Notes:   the bus itself is modelled as a simple cycle request/done handshake
package dmabms_pkg;
  localparam int          NUM_CH        = 4;
  localparam logic [1:0]  IND_CH        = 2'h3;
  localparam logic        MODE_STEAL    = 1'h0;
  localparam logic        MODE_BURST    = 1'h1;
  localparam logic [1:0]  SZ_BYTE       = 2'h0;
  localparam logic [1:0]  SZ_HALF       = 2'h1;
  localparam logic [1:0]  SZ_WORD       = 2'h2;
  localparam logic [1:0]  WIDTH_WORD    = 2'h2;
  localparam logic [1:0]  WIDTH_HALF    = 2'h1;
  localparam logic [1:0]  ONE_CYCLE     = 2'h1;
  localparam logic [1:0]  TWO_CYCLES    = 2'h2;

  typedef enum logic [1:0] {
    DMABMS_PH_PTR,
    DMABMS_PH_RD,
    DMABMS_PH_WR,
    DMABMS_PH_IDLE
  } dmabms_phase_t;

  // per-channel setup, as held in the channel control registers
  typedef struct packed {
    logic        bus_mode_select_field;
    logic        indirect;
    logic [1:0]  size;
    logic        src_ext16;
    logic        ptr_ext16;
    logic        dst_ext16;
    logic        dst_two_cycle;
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
  } dmabms_chcfg_t;

  // one bus cycle issued towards the shared system bus
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0]  size;
  } dmabms_buscyc_t;
endpackage

/* File: rtl/dmabms_arb.sv */
// Purpose: fixed priority choice among channel requests
// Assumes: requests are levels synchronous to the clock
// Notes:   purely combinational; the sequencer registers the result
`timescale 1ns/1ps
`default_nettype none
module dmabms_arb (
  // requests
  input  wire logic [3:0] req_i,
  // grant
  output logic            any_o,
  output logic [1:0]      ch_o
);
  always_comb begin
    any_o = |req_i;
    ch_o  = 2'h0;
    if (req_i[0]) begin
      ch_o = 2'h0;
    end else if (req_i[1]) begin
      ch_o = 2'h1;
    end else if (req_i[2]) begin
      ch_o = 2'h2;
    end else if (req_i[3]) begin
      ch_o = 2'h3;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/dmabms_seq.sv */
// Purpose: bus ownership and cycle sequencing for a four-channel dma controller
// Assumes: bus grant and cycle completion come from the shared bus arbiter
// Notes:   addresses and counts are not advanced here; last_i ends a channel
`timescale 1ns/1ps
`default_nettype none
module dmabms_seq (
  // clock and reset
  input  wire logic                     CLK_SYS_I,
  input  wire logic                     RST_I,
  // channel setup and requests
  input  wire dmabms_pkg::dmabms_chcfg_t CFG_I [4],
  input  wire logic [3:0]               REQ_I,
  input  wire logic [3:0]               LAST_I,
  // shared bus ownership
  output logic                          BUS_REQ_O,
  input  wire logic                     BUS_GNT_I,
  // bus cycles
  output dmabms_pkg::dmabms_buscyc_t    CYC_O,
  output logic                          IDLE_CYC_O,
  input  wire logic                     CYC_DONE_I,
  input  wire logic [31:0]              RDATA_I,
  // status
  output logic [3:0]                    UNIT_DONE_O,
  output logic [3:0]                    CH_END_O,
  output logic [1:0]                    ACT_CH_O
);
  typedef enum {ST_IDLE, ST_ACQ, ST_ISSUE, ST_WAIT, ST_NOP, ST_NEXT} dmabms_st_t;

  dmabms_st_t                 st_r;
  dmabms_pkg::dmabms_phase_t  ph_r;
  logic [1:0]                 ch_r;
  logic [1:0]                 left_r;
  logic [31:0]                ptr_r;
  logic [31:0]                data_r;
  logic                       own_r;
  logic                       arb_any;
  logic [1:0]                 arb_ch;
  dmabms_pkg::dmabms_chcfg_t  cfg;
  logic                       ind;
  logic                       half_hi;

  // a 32-bit item on a 16-bit bus needs two cycles, otherwise one
  function automatic logic [1:0] cycles_for(input logic ext16, input logic [1:0] sz);
    cycles_for = (ext16 && sz == dmabms_pkg::SZ_WORD) ? dmabms_pkg::TWO_CYCLES
                                                      : dmabms_pkg::ONE_CYCLE;
  endfunction

  dmabms_arb u_arb (
    .req_i (REQ_I),
    .any_o (arb_any),
    .ch_o  (arb_ch)
  );

  assign cfg     = CFG_I[ch_r];
  assign ind     = cfg.indirect && (ch_r == dmabms_pkg::IND_CH);
  assign half_hi = (left_r == dmabms_pkg::ONE_CYCLE);

  // ownership and phase sequencing; mode does not depend on request kind
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      st_r        <= ST_IDLE;
      ph_r        <= dmabms_pkg::DMABMS_PH_PTR;
      ch_r        <= 2'h0;
      left_r      <= 2'h0;
      own_r       <= 1'h0;
      BUS_REQ_O   <= 1'h0;
      IDLE_CYC_O  <= 1'h0;
      UNIT_DONE_O <= 4'h0;
      CH_END_O    <= 4'h0;
      ACT_CH_O    <= 2'h0;
    end else begin
      IDLE_CYC_O  <= 1'h0;
      UNIT_DONE_O <= 4'h0;
      CH_END_O    <= 4'h0;
      case (st_r)
        ST_IDLE: begin
          if (arb_any) begin
            ch_r      <= arb_ch;
            ACT_CH_O  <= arb_ch;
            BUS_REQ_O <= 1'h1;
            st_r      <= own_r ? ST_ISSUE : ST_ACQ;
          end else if (own_r) begin
            own_r     <= 1'h0;
            BUS_REQ_O <= 1'h0;
          end
        end
        ST_ACQ: begin
          if (BUS_GNT_I) begin
            own_r <= 1'h1;
            st_r  <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (ind && ph_r == dmabms_pkg::DMABMS_PH_PTR) begin
            left_r <= cycles_for(cfg.ptr_ext16, dmabms_pkg::SZ_WORD);
          end else if (ph_r == dmabms_pkg::DMABMS_PH_WR) begin
            left_r <= cfg.dst_two_cycle ? dmabms_pkg::TWO_CYCLES
                                        : cycles_for(cfg.dst_ext16, cfg.size);
          end else begin
            ph_r   <= dmabms_pkg::DMABMS_PH_RD;
            left_r <= cycles_for(ind ? cfg.src_ext16 : cfg.src_ext16, cfg.size);
          end
          st_r <= ST_WAIT;
        end
        ST_WAIT: begin
          if (CYC_DONE_I) begin
            left_r <= left_r - dmabms_pkg::ONE_CYCLE;
            if (left_r == dmabms_pkg::ONE_CYCLE) begin
              if (ph_r == dmabms_pkg::DMABMS_PH_PTR) begin
                ph_r       <= dmabms_pkg::DMABMS_PH_IDLE;
                IDLE_CYC_O <= 1'h1;
                st_r       <= ST_NOP;
              end else if (ph_r == dmabms_pkg::DMABMS_PH_RD) begin
                ph_r <= dmabms_pkg::DMABMS_PH_WR;
                st_r <= ST_ISSUE;
              end else begin
                st_r <= ST_NEXT;
              end
            end
          end
        end
        ST_NOP: begin
          ph_r <= dmabms_pkg::DMABMS_PH_RD;
          st_r <= ST_ISSUE;
        end
        ST_NEXT: begin
          UNIT_DONE_O[ch_r] <= 1'h1;
          CH_END_O[ch_r]    <= LAST_I[ch_r];
          ph_r              <= dmabms_pkg::DMABMS_PH_PTR;
          if (cfg.bus_mode_select_field == dmabms_pkg::MODE_BURST && !LAST_I[ch_r]) begin
            st_r <= ST_ISSUE;
          end else begin
            own_r     <= 1'h0;
            BUS_REQ_O <= 1'h0;
            st_r      <= ST_IDLE;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // phase returns to pointer fetch at the end of every unit, for every channel
  // captured pointer and data; halves are gathered high first
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      ptr_r  <= 32'h0;
      data_r <= 32'h0;
    end else if (st_r == ST_WAIT && CYC_DONE_I) begin
      if (ph_r == dmabms_pkg::DMABMS_PH_PTR) begin
        if (left_r == dmabms_pkg::TWO_CYCLES) begin
          ptr_r[31:16] <= RDATA_I[15:0];
        end else if (cfg.ptr_ext16) begin
          ptr_r[15:0] <= RDATA_I[15:0];
        end else begin
          ptr_r <= RDATA_I;
        end
      end else if (ph_r == dmabms_pkg::DMABMS_PH_RD) begin
        if (left_r == dmabms_pkg::TWO_CYCLES) begin
          data_r[31:16] <= RDATA_I[15:0];
        end else if (cfg.src_ext16 && cfg.size == dmabms_pkg::SZ_WORD) begin
          data_r[15:0] <= RDATA_I[15:0];
        end else begin
          data_r <= RDATA_I;
        end
      end
    end
  end

  // bus cycle presented while waiting; address per phase
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      CYC_O <= '0;
    end else begin
      CYC_O.valid <= (st_r == ST_WAIT) && !(CYC_DONE_I && half_hi);
      CYC_O.size  <= cfg.size;
      CYC_O.wdata <= data_r;
      CYC_O.write <= (ph_r == dmabms_pkg::DMABMS_PH_WR);
      if (ph_r == dmabms_pkg::DMABMS_PH_PTR) begin
        CYC_O.addr <= cfg.src_addr;
        CYC_O.size <= dmabms_pkg::SZ_WORD;
      end else if (ph_r == dmabms_pkg::DMABMS_PH_RD) begin
        CYC_O.addr <= ind ? ptr_r : cfg.src_addr;
      end else begin
        CYC_O.addr <= cfg.dst_addr;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/dmabms_properties.sv */
// Purpose: assertions on bus ownership and cycle order
// Assumes: one clock domain, async reset
// Notes:   sees only the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module dmabms_properties (
  // clock and reset
  input wire logic                       CLK_SYS_I,
  input wire logic                       RST_I,
  // requests and setup
  input wire dmabms_pkg::dmabms_chcfg_t  CFG_I [4],
  input wire logic [3:0]                 REQ_I,
  // outputs watched
  input wire logic                       BUS_REQ_O,
  input wire dmabms_pkg::dmabms_buscyc_t CYC_O,
  input wire logic                       IDLE_CYC_O,
  input wire logic [3:0]                 UNIT_DONE_O,
  input wire logic [3:0]                 CH_END_O,
  input wire logic [1:0]                 ACT_CH_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  sequence steal_unit_s;
    UNIT_DONE_O != 4'h0 && CFG_I[ACT_CH_O].bus_mode_select_field == dmabms_pkg::MODE_STEAL;
  endsequence
  sequence burst_more_s;
    UNIT_DONE_O != 4'h0 && CH_END_O == 4'h0 && REQ_I[ACT_CH_O] &&
    CFG_I[ACT_CH_O].bus_mode_select_field == dmabms_pkg::MODE_BURST;
  endsequence
  AST_ONE_UNIT: assert property ($onehot0(UNIT_DONE_O))
    else $error("unit pulse on two channels");
  AST_END_UNIT: assert property (CH_END_O != 4'h0 |-> CH_END_O == UNIT_DONE_O)
    else $error("channel end without its unit");
  AST_CYC_OWNED: assert property (CYC_O.valid |-> BUS_REQ_O)
    else $error("bus cycle without ownership");
  AST_STEAL_REL: assert property (steal_unit_s |-> ##[0:2] !BUS_REQ_O)
    else $error("steal unit kept the bus");
  AST_BURST_KEEP: assert property (burst_more_s |=> BUS_REQ_O)
    else $error("burst released the bus early");
  AST_IDLE_PULSE: assert property (IDLE_CYC_O |=> !IDLE_CYC_O)
    else $error("idle cycle longer than one");
  AST_IDLE_GAP: assert property (IDLE_CYC_O |-> !CYC_O.valid)
    else $error("bus cycle during idle cycle");
  AST_IDLE_CH3: assert property (IDLE_CYC_O |-> ACT_CH_O == dmabms_pkg::IND_CH)
    else $error("indirect idle on wrong channel");
  AST_REQ_CAUSE: assert property ($rose(BUS_REQ_O) |-> $past(REQ_I) != 4'h0)
    else $error("bus request without transfer request");
endmodule
bind dmabms_seq dmabms_properties dmabms_properties_inst (.CLK_SYS_I, .RST_I, .CFG_I, .REQ_I,
  .BUS_REQ_O, .CYC_O, .IDLE_CYC_O, .UNIT_DONE_O, .CH_END_O, .ACT_CH_O);
`default_nettype wire

/* File: testbench/dmabms_bus_model.sv */
// Purpose: shared bus grant and memory
// Assumes: read data is address plus 0x1000
// Notes:   slow mode inserts wait cycles between completions
`timescale 1ns/1ps
`default_nettype none
module dmabms_bus_model (
  input  wire logic                       clk_i,
  input  wire logic                       slow_i,
  input  wire logic                       bus_req_i,
  input  wire dmabms_pkg::dmabms_buscyc_t cyc_i,
  output logic                            gnt_o,
  output logic                            done_o,
  output logic [31:0]                     rdata_o
);
  logic [1:0] wait_r;
  initial begin
    gnt_o = 1'b0;
    done_o = 1'b0;
    rdata_o = 32'h0;
    wait_r = 2'h0;
  end
  always @(negedge clk_i) begin
    gnt_o <= bus_req_i;
    rdata_o <= ~rdata_o;
    if (done_o) begin
      done_o <= 1'b0;
    end else if (cyc_i.valid && gnt_o && wait_r == 2'h0) begin
      done_o <= 1'b1;
      rdata_o <= cyc_i.addr + 32'h1000;
      wait_r <= {slow_i, slow_i};
    end else if (wait_r != 2'h0) begin
      wait_r <= wait_r - 2'h1;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/test_dmabms_seq.sv */
// Purpose: self-checking bench for the bus-mode sequencer
// Assumes: bus model answers every cycle
// Notes:   counts cycles, idle pulses, units and bus requests
`timescale 1ns/1ps
`default_nettype none
module test_dmabms_seq;
  logic CLK_SYS_I, RST_I, BUS_REQ_O, BUS_GNT_I, IDLE_CYC_O, CYC_DONE_I, slow, bus_req_d;
  logic [3:0] REQ_I, LAST_I, UNIT_DONE_O, CH_END_O;
  logic [1:0] ACT_CH_O;
  logic [31:0] RDATA_I;
  dmabms_pkg::dmabms_chcfg_t cfg [4];
  dmabms_pkg::dmabms_buscyc_t CYC_O;
  logic [31:0] adr_q [$];
  logic [32:0] wd_q [$];
  int n_mismatch, num_checks, n_rise, n_idle, n_unit, n_end;
  dmabms_seq dmabms_seq_inst (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .CFG_I(cfg), .REQ_I(REQ_I),
    .LAST_I(LAST_I), .BUS_REQ_O(BUS_REQ_O), .BUS_GNT_I(BUS_GNT_I), .CYC_O(CYC_O),
    .IDLE_CYC_O(IDLE_CYC_O), .CYC_DONE_I(CYC_DONE_I), .RDATA_I(RDATA_I),
    .UNIT_DONE_O(UNIT_DONE_O), .CH_END_O(CH_END_O), .ACT_CH_O(ACT_CH_O));
  dmabms_bus_model dmabms_bus_model_inst (.clk_i(CLK_SYS_I), .slow_i(slow), .bus_req_i(BUS_REQ_O),
    .cyc_i(CYC_O), .gnt_o(BUS_GNT_I), .done_o(CYC_DONE_I), .rdata_o(RDATA_I));
  initial begin
    CLK_SYS_I = 1'b0;
    forever #10 CLK_SYS_I = ~CLK_SYS_I;
  end
  always @(posedge CLK_SYS_I) begin
    bus_req_d <= BUS_REQ_O;
    if (BUS_REQ_O && !bus_req_d) n_rise++;
    if (CYC_O.valid && CYC_DONE_I) adr_q.push_back(CYC_O.addr);
    if (CYC_O.valid && CYC_DONE_I) wd_q.push_back({CYC_O.write, CYC_O.wdata});
    if (IDLE_CYC_O) n_idle++;
    if (UNIT_DONE_O != 4'h0) n_unit++;
    if (CH_END_O != 4'h0) n_end++;
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic setup(input int ch, input logic md, input logic ind, input logic [1:0] sz,
                       input logic e16, input logic two);
    cfg[ch] = '{md, ind, sz, e16, e16, e16, two, 32'h100 + 32'(ch * 16), 32'h800};
  endtask
  // units: transfer units up to and including the one that ends the channel; ends: channel ends to wait for
  task automatic xfer(input logic [3:0] m, input int units, input int ends);
    int t;
    adr_q.delete();
    wd_q.delete();
    {n_rise, n_idle, n_unit, n_end} = '0;
    REQ_I = m;
    LAST_I = (units == 1) ? m : 4'h0;
    for (t = 0; t < 400 && n_end < ends; t++) begin
      @(negedge CLK_SYS_I);
      // an ended channel drops its request before the sequencer looks again
      REQ_I = REQ_I & ~CH_END_O;
      if (n_unit >= units - 1) LAST_I = m;
    end
    chk("channel ends", n_end, ends);
    REQ_I = 4'h0;
    LAST_I = 4'h0;
    repeat (4) @(negedge CLK_SYS_I);
  endtask
  task automatic t_steal;
    setup(1, dmabms_pkg::MODE_STEAL, 1'b0, dmabms_pkg::SZ_WORD, 1'b0, 1'b0);
    xfer(4'h2, 2, 1);
    chk("steal units", n_unit, 2);
    chk("steal requests", n_rise, 2);
    chk("steal cycles", adr_q.size(), 4);
  endtask
  task automatic t_burst;
    slow = 1'b1;
    setup(2, dmabms_pkg::MODE_BURST, 1'b0, dmabms_pkg::SZ_HALF, 1'b0, 1'b0);
    xfer(4'h4, 3, 1);
    slow = 1'b0;
    chk("burst units", n_unit, 3);
    chk("burst requests", n_rise, 1);
  endtask
  task automatic t_prio;
    setup(0, dmabms_pkg::MODE_STEAL, 1'b0, dmabms_pkg::SZ_BYTE, 1'b0, 1'b0);
    setup(3, dmabms_pkg::MODE_STEAL, 1'b0, dmabms_pkg::SZ_BYTE, 1'b0, 1'b0);
    xfer(4'h9, 1, 2);
    chk("first read", adr_q[0], 32'h100);
    chk("second read", adr_q[2], 32'h130);
    chk("last channel", ACT_CH_O, 32'h3);
  endtask
  task automatic t_ind_int;
    setup(3, dmabms_pkg::MODE_STEAL, 1'b1, dmabms_pkg::SZ_BYTE, 1'b0, 1'b1);
    xfer(4'h8, 1, 1);
    chk("ind cycles", adr_q.size(), 4);
    chk("ind idle", n_idle, 1);
    chk("ptr addr", adr_q[0], 32'h130);
    chk("data addr", adr_q[1], 32'h1130);
    chk("dst addr", adr_q[3], 32'h800);
    chk("data rd dir", wd_q[1][32], 32'h0);
    chk("dst wdata", wd_q[3], {1'b1, 32'h2130});
  endtask
  task automatic t_ind_ext;
    setup(3, dmabms_pkg::MODE_BURST, 1'b1, dmabms_pkg::SZ_WORD, 1'b1, 1'b0);
    xfer(4'h8, 1, 1);
    chk("ext16 cycles", adr_q.size(), 6);
    chk("ext16 idle", n_idle, 1);
    chk("ext16 ptr", adr_q[2], 32'h11301130);
    chk("ext16 wdata", wd_q[5], {1'b1, 32'h21302130});
    setup(1, dmabms_pkg::MODE_STEAL, 1'b1, dmabms_pkg::SZ_BYTE, 1'b0, 1'b0);
    xfer(4'h2, 1, 1);
    chk("ch1 cycles", adr_q.size(), 2);
    chk("ch1 idle", n_idle, 0);
  endtask
  task automatic finish_test;
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {n_mismatch, num_checks, n_rise, n_idle, n_unit, n_end} = '0;
    {REQ_I, LAST_I, slow, bus_req_d} = '0;
    for (int i = 0; i < 4; i++) setup(i, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
    RST_I = 1'b1;
    repeat (4) @(negedge CLK_SYS_I);
    RST_I = 1'b0;
    t_steal();
    t_burst();
    t_prio();
    t_ind_int();
    t_ind_ext();
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge CLK_SYS_I);
    n_mismatch++;
    finish_test();
  end
endmodule
`default_nettype wire
